/* rtl/sfi_top.sv */
// Serial flash command block: identification, pump mode, suspend, security registers.
`timescale 1ns/100ps
module sfi_top
  import sfi_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] MEM_TYPE_ID = 8'h3c,
  parameter logic [7:0] MEM_CAP_ID = 8'h15,
  parameter int TW = 32,
  parameter int PROG_CYCLES = (T_PP_US * 1000) / CLK_PERIOD_NS,
  parameter int ARRAY_ERASE_CYCLES = (T_ARRAY_ERASE_US * 1000) / CLK_PERIOD_NS,
  parameter int SEC_ERASE_CYCLES = (T_SEC_ERASE_US * 1000) / CLK_PERIOD_NS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  input wire logic SECURITY_LOCK_BIT,
  input wire logic MODE_BYTE_VALID,
  input wire logic [7:0] MODE_BYTE,
  input wire logic ARRAY_OP_START,
  input wire logic ARRAY_OP_ERASE,
  input wire logic [9:0] SECREG_RD_ADDR,
  output logic [7:0] SECREG_RD_DATA,
  output logic BUSY,
  output logic SUSPENDED,
  output logic WRITE_ENABLE_LATCH,
  output logic HIGH_SPEED_PUMP_MODE,
  output logic CONT_READ_MODE
);

  // Maker, type and capacity bytes; the default values are arbitrary.
  localparam logic [23:0] ID_WORD = {MAKER_ID, MEM_TYPE_ID, MEM_CAP_ID};

  // ---------------- Link side, clocked by the serial clock ----------------
  // Chip select high clears only the frame position, identification enable and serial output; the captured opcode,
  // address, bit count and page latch stay put so that the system side can
  // read them after it has seen chip select rise. They are stable then
  // because the host gives no clock edge while deselected.
  logic [11:0] bit_cnt_r, bit_cnt_nxt;
  logic id_en_r, id_en_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [11:0] bits_r, bits_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic data_byte;
  logic [7:0] page_r [0:SEC_REG_BYTES-1];
  logic [SEC_REG_BYTES-1:0] pvalid_r;
  logic [1:0] link_flags;
  logic busy_l, cont_l;
  logic so_nxt, so_oe_nxt;
  logic [11:0] id_idx;

  logic busy_r, busy_nxt;
  logic cont_r, cont_nxt;

  sfi_sync #(.W(2)) u_link_sync (
    .clk(SCLK),
    .d({busy_r, cont_r}),
    .q(link_flags)
  );
  assign busy_l = link_flags[1];
  assign cont_l = link_flags[0];

  assign data_byte = (bit_cnt_r >= BIT_FIRST_DATA_END) && (bit_cnt_r[2:0] == 3'h7);

  always_comb begin
    bit_nxt_calc: begin
      bit_cnt_nxt = (bit_cnt_r == BITS_SAT) ? bit_cnt_r : bit_cnt_r + 12'h001;
    end
    sh_nxt = {sh_r[6:0], SI};
    bits_nxt = bit_cnt_nxt;
    opc_nxt = opc_r;
    addr_nxt = addr_r;
    id_en_nxt = id_en_r;
    ptr_nxt = ptr_r;
    if (bit_cnt_r == BIT_LAST_OPC) begin
      opc_nxt = sh_nxt;
      // Not decoded during a running cycle or in continuous read mode.
      id_en_nxt = (sh_nxt == OP_READ_ID) && !busy_l && !cont_l;
    end
    if ((bit_cnt_r >= BITS_OPCODE) && (bit_cnt_r < BITS_ADDR_END)) begin
      addr_nxt = {addr_r[22:0], SI};
    end
    if (bit_cnt_r == BIT_LAST_ADDR) begin
      ptr_nxt = {addr_r[6:0], SI};
    end else if (data_byte) begin
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_r <= 12'h000;
      id_en_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      id_en_r <= id_en_nxt;
    end
  end

  always_ff @(posedge SCLK) begin
    sh_r <= sh_nxt;
    opc_r <= opc_nxt;
    addr_r <= addr_nxt;
    bits_r <= bits_nxt;
    ptr_r <= ptr_nxt;
  end

  // Page latch for the security program data; bytes wrap inside 256.
  always_ff @(posedge SCLK) begin
    if (bit_cnt_r == 12'h000) begin
      pvalid_r <= '0;
    end else if (data_byte) begin
      page_r[ptr_r] <= sh_nxt;
      pvalid_r[ptr_r] <= 1'b1;
    end
  end

  always_comb begin
    id_idx = bit_cnt_r - BITS_OPCODE;
    so_nxt = 1'b0;
    so_oe_nxt = 1'b0;
    if (id_en_r && (bit_cnt_r >= BITS_OPCODE) && (id_idx < 12'd24)) begin
      so_nxt = ID_WORD[5'(5'd23 - id_idx[4:0])];
      so_oe_nxt = 1'b1;
    end
  end

  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end else begin
      SO <= so_nxt;
      SO_OE <= so_oe_nxt;
    end
  end

  // ---------------- System side, clocked by CLK ----------------
  logic cs_q;
  logic cs_d_r;
  logic cs_rise;

  sfi_sync #(.W(1)) u_cs_sync (
    .clk(CLK),
    .d(CS_N),
    .q(cs_q)
  );

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cs_d_r <= 1'b1;
    end else begin
      cs_d_r <= cs_q;
    end
  end
  assign cs_rise = cs_q && !cs_d_r;

  sfi_state_e st_r, st_nxt;
  sfi_kind_e kind_r, kind_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [15:0] lat_r, lat_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic wel_r, wel_nxt;
  logic hsm_r, hsm_nxt;
  logic sus_r, sus_nxt;
  logic sec_ok;
  logic commit;

  // Security writes need the latch, no lock, and an idle, unsuspended engine.
  assign sec_ok = wel_r && !SECURITY_LOCK_BIT && (st_r == ST_IDLE);

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    tmr_nxt = tmr_r;
    lat_nxt = lat_r;
    sel_nxt = sel_r;
    wel_nxt = wel_r;
    hsm_nxt = hsm_r;
    cont_nxt = cont_r;
    case (st_r)
      ST_RUN: begin
        if (tmr_r == '0) begin
          st_nxt = ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - TW'(1);
        end
      end
      ST_SUSPENDING: begin
        if (lat_r == 16'h0000) begin
          st_nxt = ST_SUSPENDED;
        end else begin
          lat_nxt = lat_r - 16'h0001;
        end
      end
      ST_SUSPENDED: begin
        st_nxt = ST_SUSPENDED;
      end
      ST_IDLE: begin
        // Array operations start only from idle, never while suspended.
        if (ARRAY_OP_START) begin
          st_nxt = ST_RUN;
          kind_nxt = ARRAY_OP_ERASE ? K_ARR_ERASE : K_ARR_PROG;
          tmr_nxt = ARRAY_OP_ERASE ? TW'(ARRAY_ERASE_CYCLES) : TW'(PROG_CYCLES);
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (cs_rise && cont_r) begin
      if ((opc_r == OP_MODE_RESET) && (bits_r >= BITS_OPCODE)) begin
        cont_nxt = 1'b0;
      end
    end else if (cs_rise) begin
      case (opc_r)
        OP_WRITE_ENABLE: begin
          if (bits_r == BITS_OPCODE) begin
            wel_nxt = 1'b1;
            hsm_nxt = 1'b0;
          end
        end
        OP_DEEP_PD: begin
          if (bits_r == BITS_OPCODE) begin
            hsm_nxt = 1'b0;
          end
        end
        OP_RELEASE_PD: begin
          if (bits_r >= BITS_OPCODE) begin
            hsm_nxt = 1'b0;
          end
        end
        OP_HIGH_SPEED: begin
          if (bits_r == BITS_ADDR_END) begin
            hsm_nxt = 1'b1;
          end
        end
        OP_SUSPEND: begin
          // Only a running array program or erase may be suspended.
          if ((bits_r == BITS_OPCODE) && (st_r == ST_RUN) && !sus_r &&
              ((kind_r == K_ARR_PROG) || (kind_r == K_ARR_ERASE))) begin
            st_nxt = ST_SUSPENDING;
            tmr_nxt = tmr_r;
            lat_nxt = 16'(SUS_CYC);
          end
        end
        OP_RESUME: begin
          if ((bits_r == BITS_OPCODE) && (st_r == ST_SUSPENDED)) begin
            st_nxt = ST_RUN;
          end
        end
        OP_SEC_ERASE: begin
          // The erase must end exactly after its address bytes.
          if ((bits_r == BITS_ADDR_END) && (addr_r[23:10] == 14'h0000) && sec_ok) begin
            st_nxt = ST_RUN;
            kind_nxt = K_SEC_ERASE;
            tmr_nxt = TW'(SEC_ERASE_CYCLES);
            sel_nxt = addr_r[9:8];
            wel_nxt = 1'b0;
          end
        end
        OP_SEC_PROG: begin
          if ((bits_r >= BITS_PROG_MIN) && (bits_r[2:0] == 3'h0) &&
              (addr_r[23:10] == 14'h0000) && sec_ok) begin
            st_nxt = ST_RUN;
            kind_nxt = K_SEC_PROG;
            tmr_nxt = TW'(PROG_CYCLES);
            sel_nxt = addr_r[9:8];
            wel_nxt = 1'b0;
          end
        end
        default: begin
          wel_nxt = wel_r;
        end
      endcase
    end
    if (MODE_BYTE_VALID) begin
      cont_nxt = (MODE_BYTE[7:4] == CONT_MODE_NIBBLE);
    end
    busy_nxt = (st_nxt == ST_RUN) || (st_nxt == ST_SUSPENDING);
    sus_nxt = (st_nxt == ST_SUSPENDING) || (st_nxt == ST_SUSPENDED);
  end

  // Power-up reset drops any suspension and volatile mode state.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r <= ST_IDLE;
      kind_r <= K_ARR_PROG;
      tmr_r <= '0;
      lat_r <= 16'h0000;
      sel_r <= 2'h0;
      wel_r <= 1'b0;
      hsm_r <= 1'b0;
      cont_r <= 1'b0;
      busy_r <= 1'b0;
      sus_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      tmr_r <= tmr_nxt;
      lat_r <= lat_nxt;
      sel_r <= sel_nxt;
      wel_r <= wel_nxt;
      hsm_r <= hsm_nxt;
      cont_r <= cont_nxt;
      busy_r <= busy_nxt;
      sus_r <= sus_nxt;
    end
  end

  // The suspended flag reaches array read logic, which stays usable.
  assign BUSY = busy_r;
  assign SUSPENDED = sus_r;
  assign WRITE_ENABLE_LATCH = wel_r;
  assign HIGH_SPEED_PUMP_MODE = hsm_r;
  assign CONT_READ_MODE = cont_r;

  // Security storage is written only when its self-timed cycle ends.
  // Programming can only clear bits, as in the real cells.
  logic [7:0] sec_mem [0:SEC_REG_COUNT*SEC_REG_BYTES-1];
  assign commit = (st_r == ST_RUN) && (tmr_r == '0) &&
                  ((kind_r == K_SEC_ERASE) || (kind_r == K_SEC_PROG));

  always_ff @(posedge CLK) begin
    if (commit) begin
      for (int i = 0; i < SEC_REG_BYTES; i++) begin
        if (kind_r == K_SEC_ERASE) begin
          sec_mem[{sel_r, 8'(i)}] <= MEM_ERASED;
        end else if (pvalid_r[i]) begin
          sec_mem[{sel_r, 8'(i)}] <= sec_mem[{sel_r, 8'(i)}] & page_r[i];
        end
      end
    end
    SECREG_RD_DATA <= sec_mem[SECREG_RD_ADDR];
  end

endmodule : sfi_top

/* shared/sfi_pkg.sv */
// Constants, opcodes, timing counts and types shared by the serial flash command block.
// Functional notes
// - Identification read returns maker byte, then memory type byte, then capacity byte.
// - Identification read is not decoded while a program or erase cycle runs.
// - The 24 identification bits change on falling serial clock edges.
// - Chip select rise ends identification output at any point; device goes standby.
// - Release, write enable or deep power-down commands leave pump mode.
// - Mode byte with upper nibble A lets the next fast read skip its opcode.
// - In continuous mode only the mode reset command is recognized; it clears the mode.
// - Suspend accepted only during array program or erase with busy set, not suspended.
// - While suspended, status write, security ops, erases and page program are refused.
// - Accepted suspend sets suspended at once and clears busy within the latency.
// - While suspended, array reads from other sectors stay allowed.
// - Power loss resets the device; suspension does not survive power-up.
// - Resume only when suspended and idle; clears suspended, sets busy within 200 ns.
// - Four separate 256-byte security registers, each erased and programmed alone.
// - Security erase or program is performed only with the write enable latch set.
// - Security erase is dropped unless chip select rises exactly after its last bit.
// - Security cycle starts at chip select rise; busy until done; latch clears before end.
// - Once the lock bit is set, security erase and program are ignored forever; the code ignores them only while SECURITY_LOCK_BIT is high.
package sfi_pkg;

  localparam int CLK_PERIOD_NS = 40;

  localparam logic [7:0] OP_READ_ID = 8'h9f;
  localparam logic [7:0] OP_HIGH_SPEED = 8'ha3;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_RELEASE_PD = 8'hab;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_DEEP_PD = 8'hb9;

  localparam logic [11:0] BITS_OPCODE = 12'h008;
  localparam logic [11:0] BITS_ADDR_END = 12'h020;
  localparam logic [11:0] BITS_PROG_MIN = 12'h028;
  localparam logic [11:0] BITS_SAT = 12'hfff;
  localparam logic [11:0] BIT_LAST_OPC = 12'h007;
  localparam logic [11:0] BIT_LAST_ADDR = 12'h01f;
  localparam logic [11:0] BIT_FIRST_DATA_END = 12'h027;

  localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
  localparam logic [7:0] MEM_ERASED = 8'hff;
  localparam int SEC_REG_BYTES = 256;
  localparam int SEC_REG_COUNT = 4;

  localparam int T_PP_US = 700;
  localparam int T_ARRAY_ERASE_US = 45000;
  localparam int T_SEC_ERASE_US = 45000;
  localparam int T_SUS_US = 20;
  localparam int SUS_CYC = (T_SUS_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {K_ARR_PROG, K_ARR_ERASE, K_SEC_ERASE, K_SEC_PROG} sfi_kind_e;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SUSPENDING, ST_SUSPENDED} sfi_state_e;

endpackage : sfi_pkg

/* rtl/sfi_sync.sv */
// Two-flop level synchroniser for a bundle of independent slow levels.
`timescale 1ns/100ps
module sfi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule : sfi_sync

/* tb/sfi_top_sva.sv */
// Port-level assertions for the serial flash command block.
`timescale 1ns/100ps
module sfi_top_sva
  import sfi_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic SECURITY_LOCK_BIT,
  input wire logic MODE_BYTE_VALID,
  input wire logic [7:0] MODE_BYTE,
  input wire logic ARRAY_OP_START,
  input wire logic BUSY,
  input wire logic SUSPENDED,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic HIGH_SPEED_PUMP_MODE,
  input wire logic CONT_READ_MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_oe_off_cs: assert property (CS_N && $past(CS_N) |-> !SO_OE)
    else $error("output enabled while deselected");
  a_so_quiet: assert property (!SO_OE |-> !SO)
    else $error("serial out not low while released");
  a_sus_on_busy: assert property ($rose(SUSPENDED) |-> BUSY && $past(BUSY))
    else $error("suspend taken without a running cycle");
  a_sus_drop_busy: assert property ($rose(SUSPENDED) |-> ##[1:600] !BUSY)
    else $error("busy not cleared after suspend");
  a_resume_busy: assert property ($fell(SUSPENDED) |-> !$past(BUSY) ##[0:5] BUSY)
    else $error("resume did not restart the cycle");
  a_sus_blocks: assert property ($past(SUSPENDED) && SUSPENDED |-> !$rose(BUSY))
    else $error("cycle started while suspended");
  // A busy rise that no array start or resume explains is a security cycle.
  a_sec_gate: assert property ($rose(BUSY) && !$past(SUSPENDED) && !$past(ARRAY_OP_START) &&
    !$past(ARRAY_OP_START, 2) |-> $past(WRITE_ENABLE_LATCH) && !$past(SECURITY_LOCK_BIT) &&
    !WRITE_ENABLE_LATCH)
    else $error("security cycle without latch or while locked");
  a_cont_set: assert property (MODE_BYTE_VALID && MODE_BYTE[7:4] == CONT_MODE_NIBBLE
    |=> CONT_READ_MODE)
    else $error("continuous mode not entered");
  a_cont_clear: assert property (MODE_BYTE_VALID && MODE_BYTE[7:4] != CONT_MODE_NIBBLE
    |=> !CONT_READ_MODE)
    else $error("continuous mode entered on wrong byte");
  c_suspend: cover property ($rose(SUSPENDED));
  c_pump: cover property ($rose(HIGH_SPEED_PUMP_MODE));
  c_id_out: cover property ($fell(SO_OE));
endmodule : sfi_top_sva

/* tb/sfi_host_model.sv */
// Host serial master model driving frames at the 64 ns link clock.
`timescale 1ns/100ps
module sfi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic last;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    last = 1'b0;
    // A clean deselect edge clears the output flops, which only chip select resets.
    #5 cs_n = 1'b1;
  end
  // A released output is read as the inverse of its last level, never as a held value.
  task automatic frame(input logic [7:0] q[$], input int n, output logic [23:0] rd,
    output logic oe);
    rd = 24'h000000;
    oe = 1'b0;
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = (i < 8 * q.size()) ? q[i / 8][7 - i % 8] : 1'b0;
      #32 sclk = 1'b1;
      last = so_oe ? so : !last;
      oe = oe | so_oe;
      if (i >= 8) begin
        rd = {rd[22:0], last};
      end
      #32 sclk = 1'b0;
    end
    // Chip select rises only on a whole bit; 300 ns keeps frames over six clocks apart.
    #32 cs_n = 1'b1;
    #300;
  endtask : frame
endmodule : sfi_host_model

/* tb/tb_top.sv */
// Self-checking bench for the serial flash command block.
`timescale 1ns/100ps
module tb_top;
  import sfi_pkg::*;
  // Identification bytes are arbitrary values.
  localparam logic [7:0] ID_M = 8'h31;
  localparam logic [7:0] ID_T = 8'h42;
  localparam logic [7:0] ID_C = 8'h17;
  logic CLK, RESET, SCLK, CS_N, SI, SO, SO_OE, SECURITY_LOCK_BIT, MODE_BYTE_VALID, oe;
  logic ARRAY_OP_START, ARRAY_OP_ERASE, BUSY, SUSPENDED, WRITE_ENABLE_LATCH;
  logic HIGH_SPEED_PUMP_MODE, CONT_READ_MODE;
  logic [7:0] MODE_BYTE, SECREG_RD_DATA, ad, dt, m;
  logic [9:0] SECREG_RD_ADDR;
  logic [23:0] rd;
  logic [1:0] rg;
  logic [7:0] ex [3] = '{OP_DEEP_PD, OP_RELEASE_PD, OP_WRITE_ENABLE};
  int fails, comparisons, seed;
  sfi_top #(.MAKER_ID(ID_M), .MEM_TYPE_ID(ID_T), .MEM_CAP_ID(ID_C), .PROG_CYCLES(30),
    .ARRAY_ERASE_CYCLES(2000), .SEC_ERASE_CYCLES(40)) uut (
    .CLK(CLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE),
    .SECURITY_LOCK_BIT(SECURITY_LOCK_BIT), .MODE_BYTE_VALID(MODE_BYTE_VALID),
    .MODE_BYTE(MODE_BYTE), .ARRAY_OP_START(ARRAY_OP_START), .ARRAY_OP_ERASE(ARRAY_OP_ERASE),
    .SECREG_RD_ADDR(SECREG_RD_ADDR), .SECREG_RD_DATA(SECREG_RD_DATA), .BUSY(BUSY),
    .SUSPENDED(SUSPENDED), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
    .HIGH_SPEED_PUMP_MODE(HIGH_SPEED_PUMP_MODE), .CONT_READ_MODE(CONT_READ_MODE));
  sfi_host_model host (.sclk(SCLK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe(SO_OE));
  function automatic logic [23:0] exp_id();
    return {ID_M, ID_T, ID_C};
  endfunction : exp_id
  function automatic logic exp_cont(input logic [7:0] b);
    return b[7:4] == CONT_MODE_NIBBLE;
  endfunction : exp_cont
  task automatic chk_flag(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  task automatic chk_data(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data
  task automatic cmd(input logic [7:0] b);
    host.frame('{b}, 8, rd, oe);
  endtask : cmd
  task automatic sec(input logic [7:0] op, input int n);
    host.frame('{op, 8'h00, {6'h00, rg}, ad, dt}, n, rd, oe);
  endtask : sec
  task automatic mode(input logic [7:0] b);
    @(posedge CLK) MODE_BYTE_VALID <= 1'b1;
    MODE_BYTE <= b;
    @(posedge CLK) MODE_BYTE_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
  endtask : mode
  task automatic wait_idle();
    for (int i = 0; i < 200 && BUSY !== 1'b0; i++) @(posedge CLK);
    #1 chk_flag("idle_wait", 1'b0, BUSY);
  endtask : wait_idle
  task automatic rsec(input logic [7:0] e);
    @(posedge CLK) SECREG_RD_ADDR <= {rg, ad};
    repeat (2) @(posedge CLK);
    #1 chk_data("secreg", {16'h0000, e}, {16'h0000, SECREG_RD_DATA});
  endtask : rsec
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    #2000000;
    fails++;
    close_out();
  end
  initial begin
    seed = 53182;
    RESET = 1'b1;
    SECURITY_LOCK_BIT = 1'b0;
    MODE_BYTE_VALID = 1'b0;
    MODE_BYTE = 8'h00;
    ARRAY_OP_START = 1'b0;
    ARRAY_OP_ERASE = 1'b0;
    SECREG_RD_ADDR = 10'h000;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    host.frame('{OP_READ_ID}, 32, rd, oe);
    chk_data("id", exp_id(), rd);
    host.frame('{OP_READ_ID}, 19, rd, oe);
    host.frame('{OP_READ_ID}, 32, rd, oe);
    chk_data("id_after_cut", exp_id(), rd);
    $display("test id done");
    for (int i = 0; i < 3; i++) begin
      m = 8'($random(seed));
      if (i != 1) m[7:4] = CONT_MODE_NIBBLE;
      else if (m[7:4] == CONT_MODE_NIBBLE) m[7] = 1'b0;
      mode(m);
      chk_flag("cont_mode", exp_cont(m), CONT_READ_MODE);
    end
    cmd(OP_WRITE_ENABLE);
    chk_flag("wel_in_cont", 1'b0, WRITE_ENABLE_LATCH);
    host.frame('{OP_READ_ID}, 32, rd, oe);
    chk_flag("id_in_cont", 1'b0, oe);
    cmd(OP_MODE_RESET);
    chk_flag("cont_reset", 1'b0, CONT_READ_MODE);
    $display("test continuous done");
    host.frame('{OP_HIGH_SPEED, 8'h00, 8'h00, 8'h00}, 40, rd, oe);
    chk_flag("pump_len", 1'b0, HIGH_SPEED_PUMP_MODE);
    // Deep power-down is always followed by a release before any identification read.
    foreach (ex[i]) begin
      host.frame('{OP_HIGH_SPEED, 8'h00, 8'h00, 8'h00}, 32, rd, oe);
      chk_flag("pump_on", 1'b1, HIGH_SPEED_PUMP_MODE);
      cmd(ex[i]);
      chk_flag("pump_off", 1'b0, HIGH_SPEED_PUMP_MODE);
    end
    $display("test pump done");
    rg = 2'($random(seed));
    ad = 8'($random(seed));
    dt = 8'($random(seed));
    sec(OP_SEC_ERASE, 32);
    chk_flag("erase_busy", 1'b1, BUSY);
    chk_flag("erase_wel", 1'b0, WRITE_ENABLE_LATCH);
    wait_idle();
    rsec(MEM_ERASED);
    sec(OP_SEC_PROG, 40);
    chk_flag("prog_no_wel", 1'b0, BUSY);
    cmd(OP_WRITE_ENABLE);
    sec(OP_SEC_PROG, 40);
    wait_idle();
    rsec(dt);
    rg = rg + 2'd1;
    cmd(OP_WRITE_ENABLE);
    sec(OP_SEC_PROG, 48);
    wait_idle();
    rg = rg - 2'd1;
    rsec(dt);
    cmd(OP_WRITE_ENABLE);
    sec(OP_SEC_ERASE, 33);
    chk_flag("erase_cut", 1'b0, BUSY);
    cmd(OP_WRITE_ENABLE);
    @(posedge CLK) SECURITY_LOCK_BIT <= 1'b1;
    sec(OP_SEC_ERASE, 32);
    chk_flag("erase_locked", 1'b0, BUSY);
    rsec(dt);
    @(posedge CLK) SECURITY_LOCK_BIT <= 1'b0;
    $display("test security done");
    cmd(OP_SUSPEND);
    chk_flag("sus_idle", 1'b0, SUSPENDED);
    cmd(OP_RESUME);
    chk_flag("resume_idle", 1'b0, BUSY);
    @(posedge CLK) ARRAY_OP_START <= 1'b1;
    @(posedge CLK) ARRAY_OP_START <= 1'b0;
    cmd(OP_SUSPEND);
    chk_flag("sus_prog", 1'b1, SUSPENDED);
    repeat (520) @(posedge CLK);
    cmd(OP_RESUME);
    wait_idle();
    chk_flag("prog_done_sus", 1'b0, SUSPENDED);
    @(posedge CLK) ARRAY_OP_START <= 1'b1;
    ARRAY_OP_ERASE <= 1'b1;
    @(posedge CLK) ARRAY_OP_START <= 1'b0;
    host.frame('{OP_READ_ID}, 32, rd, oe);
    chk_flag("id_busy", 1'b0, oe);
    cmd(OP_SUSPEND);
    chk_flag("sus_flag", 1'b1, SUSPENDED);
    chk_flag("sus_busy", 1'b1, BUSY);
    repeat (520) @(posedge CLK);
    #1 chk_flag("sus_idle_busy", 1'b0, BUSY);
    cmd(OP_WRITE_ENABLE);
    sec(OP_SEC_ERASE, 32);
    chk_flag("sus_refuse", 1'b0, BUSY);
    cmd(OP_RESUME);
    chk_flag("res_flag", 1'b0, SUSPENDED);
    chk_flag("res_busy", 1'b1, BUSY);
    cmd(OP_SUSPEND);
    @(posedge CLK) RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk_flag("power_sus", 1'b0, SUSPENDED);
    $display("test suspend done");
    close_out();
  end
endmodule : tb_top
bind sfi_top sfi_top_sva chk (.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .SO(SO), .SO_OE(SO_OE),
  .SECURITY_LOCK_BIT(SECURITY_LOCK_BIT), .MODE_BYTE_VALID(MODE_BYTE_VALID),
  .MODE_BYTE(MODE_BYTE), .ARRAY_OP_START(ARRAY_OP_START), .BUSY(BUSY), .SUSPENDED(SUSPENDED),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .HIGH_SPEED_PUMP_MODE(HIGH_SPEED_PUMP_MODE),
  .CONT_READ_MODE(CONT_READ_MODE));
